// File: dssr_pkg.sv
// Purpose: Shared constants and types for the dual static recirculating shift register.
// Assumes: One system clock at 40 MHz; the shift clock arrives as a pin.
// Notes: Register lengths and timing figures are defined here; the monitor and bench repeat some of them as literals.
package dssr_pkg;
    localparam int LONG_LEN = 512;
    localparam int SHORT_LEN = 480;
    localparam int SYNC_STAGES = 3;
    localparam int REF_CLK_MHZ = 40;
    // Longest high phase of the shift clock, in microseconds.
    localparam int HIGH_MAX_US = 100;
    localparam int HIGH_MAX_CYC = HIGH_MAX_US * REF_CLK_MHZ;

    typedef enum logic [1:0] {
        DSSR_LOW = 2'b00,
        DSSR_HIGH = 2'b01
    } dssr_phase_type;

    typedef struct packed {
        logic shift_clk;
        logic select;
        logic data_a;
        logic data_b;
    } dssr_pins_type;
endpackage : dssr_pkg

// File: dssr_ring.sv
// Purpose: One serial register of configurable length, held in a bit memory.
// Assumes: Advance pulses come from the owning module on the system clock.
// Notes: Output bit comes from a register; no reset of contents.
`timescale 1ns/1ps
`default_nettype none
module dssr_ring
    import dssr_pkg::*;
#(
    parameter int LEN = LONG_LEN
)
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic advance_in,
    input wire logic write_in,
    input wire logic data_in,
    output logic data_out
);
    localparam int AW = $clog2(LEN);
    initial
    begin
        if (LEN < 2)
        begin
            $error("dssr_ring: LEN must be at least 2");
        end
    end

    logic mem [0:LEN-1];
    logic [AW-1:0] ptr_r;
    logic out_r;
    logic fb;

    // The pointer marks the oldest bit, which leaves as the new bit enters.
    assign fb = write_in ? data_in : mem[ptr_r];
    always_ff @(posedge clk_in)
    begin
        if (advance_in)
        begin
            mem[ptr_r] <= fb;
        end
    end
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            ptr_r <= '0;
            out_r <= 1'b0;
        end
        else if (advance_in)
        begin
            ptr_r <= (ptr_r == AW'(LEN - 1)) ? '0 : ptr_r + 1'b1;
            out_r <= mem[(ptr_r == AW'(LEN - 1)) ? '0 : ptr_r + 1'b1];
        end
    end
    assign data_out = out_r;
endmodule : dssr_ring
`default_nettype wire

// File: dssr_top.sv
// Purpose: Dual static shift register with write or recirculate select.
// Assumes: Shift clock, select and serial data are asynchronous pins.
// Notes: Contents survive any low pause; capture is on the falling edge.
//        The watch output flags a clock high phase that runs past the limit.
//        Register contents have no reset and read unknown until written.
`timescale 1ns/1ps
`default_nettype none
module dssr_top
    import dssr_pkg::*;
#(
    parameter int REG_LEN = LONG_LEN
)
(
    input wire logic REF_CLK_IN,
    input wire logic RST_IN,
    input wire logic SHIFT_CLK_IN,
    input wire logic SELECT_IN,
    input wire logic FIRST_SERIAL_INPUT_IN,
    input wire logic SECOND_SERIAL_INPUT_IN,
    output logic FIRST_SERIAL_OUTPUT_OUT,
    output logic SECOND_SERIAL_OUTPUT_OUT,
    output logic HIGH_TOO_LONG_OUT
);
    // ****************************************
    // Elaboration checks
    // ****************************************
    // Both channels are built from one loop; the count is fixed by the device.
    localparam int CHANNELS = 2;
    // The high-phase counter must reach the limit without wrapping.
    localparam int CNT_W = $clog2(HIGH_MAX_CYC + 1);

    initial
    begin
        if (REG_LEN != LONG_LEN && REG_LEN != SHORT_LEN)
        begin
            $error("dssr_top: REG_LEN must be 512 or 480");
        end
        if (HIGH_MAX_CYC < 1)
        begin
            $error("dssr_top: the high-phase limit must be at least one cycle");
        end
        if (SYNC_STAGES != 3)
        begin
            $error("dssr_top: the pin filter is built for three stages");
        end
    end

    // ****************************************
    // Pin synchronisers and state
    // ****************************************
    // Stages s1 to s3 filter the pins; master holds the bit taken while the clock is high.
    typedef struct packed {
        dssr_pins_type s1;
        dssr_pins_type s2;
        dssr_pins_type s3;
        dssr_phase_type phase;
        dssr_pins_type master;
        logic advance;
        logic [CNT_W-1:0] high_cnt;
        logic too_long;
    } dssr_state_type;

    dssr_state_type st_r;
    dssr_state_type st_nxt;
    dssr_pins_type pins;
    logic [CHANNELS-1:0] ch_in;
    logic [CHANNELS-1:0] ch_out;
    // Helper levels read from the filter stages and the high-phase counter.
    logic clk_high_seen;
    logic clk_low_seen;
    logic sync_steady;
    logic high_expired;

    // ****************************************
    // Pin filter
    // ****************************************
    always_comb
    begin
        pins.shift_clk = SHIFT_CLK_IN;
        pins.select = SELECT_IN;
        pins.data_a = FIRST_SERIAL_INPUT_IN;
        pins.data_b = SECOND_SERIAL_INPUT_IN;
    end

    // A level counts only once the second and third stages agree, so a pin
    // that moves right at a sample edge is never taken half-way.
    assign clk_high_seen = st_r.s2.shift_clk && st_r.s3.shift_clk;
    assign clk_low_seen = !st_r.s2.shift_clk && !st_r.s3.shift_clk;
    assign sync_steady = (st_r.s2 == st_r.s3);
    assign high_expired = (st_r.high_cnt >= CNT_W'(HIGH_MAX_CYC));

    // ****************************************
    // Phase machine
    // ****************************************
    // Tracks the filtered shift clock and makes one advance pulse per falling edge.
    always_comb
    begin
        st_nxt = st_r;
        // Each filter stage copies the one before it.
        st_nxt.s1 = pins;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        st_nxt.advance = 1'b0;
        unique case (st_r.phase)
            DSSR_LOW:
            begin
                // While low, the master stage is left alone so late input changes cannot leak in.
                // The limit counter restarts with every high phase.
                if (clk_high_seen)
                begin
                    st_nxt.phase = DSSR_HIGH;
                    st_nxt.high_cnt = '0;
                end
            end
            DSSR_HIGH:
            begin
                // Master stage follows the inputs while the clock is high.
                if (sync_steady)
                begin
                    st_nxt.master = st_r.s3;
                end
                // The counter saturates, so it never wraps while the clock stays high.
                if (!high_expired)
                begin
                    st_nxt.high_cnt = st_r.high_cnt + 1'b1;
                end
                else
                begin
                    st_nxt.too_long = 1'b1;
                end
                // A falling edge advances both registers, writing the master bits only when the master select is high.
                if (clk_low_seen)
                begin
                    st_nxt.phase = DSSR_LOW;
                    st_nxt.advance = 1'b1;
                    st_nxt.too_long = 1'b0;
                end
            end
            default:
            begin
                // An unused code returns to the idle low phase.
                st_nxt.phase = DSSR_LOW;
            end
        endcase
    end

    // ****************************************
    // State register
    // ****************************************
    // Reset clears the filter and the phase; stored bits are left as they are.
    always_ff @(posedge REF_CLK_IN)
    begin
        if (RST_IN)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // Two independent registers
    // ****************************************
    // Both channels share the advance pulse and the select level, but each keeps
    // storage of its own, so neither ever sees the other's bits.
    // Contents advance only on a falling edge, so a low pause holds them.
    assign ch_in[0] = st_r.master.data_a;
    assign ch_in[1] = st_r.master.data_b;

    generate
        for (genvar ch = 0; ch < CHANNELS; ch++)
        begin : g_channel
            dssr_ring #(
                .LEN(REG_LEN)
            )
            u_ring (
                .clk_in(REF_CLK_IN),
                .rst_in(RST_IN),
                .advance_in(st_r.advance),
                .write_in(st_r.master.select),
                .data_in(ch_in[ch]),
                .data_out(ch_out[ch])
            );
        end
    endgenerate

    // ****************************************
    // Output registers
    // ****************************************
    // Every pin is driven from a flip-flop so the outputs never glitch.
    // The watch flag only reports a high phase past the limit; the bit taken at
    // the fall is still stored, and the user must treat it as suspect.
    always_ff @(posedge REF_CLK_IN)
    begin
        if (RST_IN)
        begin
            FIRST_SERIAL_OUTPUT_OUT <= 1'b0;
            SECOND_SERIAL_OUTPUT_OUT <= 1'b0;
            HIGH_TOO_LONG_OUT <= 1'b0;
        end
        else
        begin
            FIRST_SERIAL_OUTPUT_OUT <= ch_out[0];
            SECOND_SERIAL_OUTPUT_OUT <= ch_out[1];
            HIGH_TOO_LONG_OUT <= st_r.too_long;
        end
    end
endmodule : dssr_top
`default_nettype wire

// File: dssr_top_monitor.sv
// Purpose: Pin checks. Assumes: Phases of four cycles or more. Notes: Bound by name.
`timescale 1ns/1ps
`default_nettype none
module dssr_top_monitor
    import dssr_pkg::*;
#(parameter int REG_LEN = LONG_LEN)
(
    input wire logic REF_CLK_IN,
    input wire logic RST_IN,
    input wire logic SHIFT_CLK_IN,
    input wire logic SELECT_IN,
    input wire logic FIRST_SERIAL_OUTPUT_OUT,
    input wire logic SECOND_SERIAL_OUTPUT_OUT,
    input wire logic HIGH_TOO_LONG_OUT
);
    logic [12:0] hi_r;
    wire [1:0] q = {FIRST_SERIAL_OUTPUT_OUT, SECOND_SERIAL_OUTPUT_OUT};
    wire f = HIGH_TOO_LONG_OUT;
    always_ff @(posedge REF_CLK_IN)
        hi_r <= (RST_IN || !SHIFT_CLK_IN) ? 13'h0 : hi_r + {12'h0, !(&hi_r)};
    default clocking @(posedge REF_CLK_IN);
    endclocking
    default disable iff (RST_IN);
    AST_LOW: assert property (!SHIFT_CLK_IN [*8] |=> $stable(q)) else $error("low");
    AST_HIGH: assert property (SHIFT_CLK_IN [*8] |=> $stable(q)) else $error("high");
    AST_STEP: assert property ($changed(q) |=> $stable(q) [*3]) else $error("step");
    AST_RST: assert property ($fell(RST_IN) |-> q == 2'h0 && !f) else $error("reset");
    AST_SET: assert property (hi_r > 13'hFAA |-> f) else $error("no flag");
    AST_QUIET: assert property (hi_r inside {[13'h8:13'hF96]} |-> !f) else $error("flag");
    AST_CLR: assert property (!SHIFT_CLK_IN [*8] |-> !f) else $error("stuck");
    cover property ($fell(SHIFT_CLK_IN) && SELECT_IN);
    cover property ($fell(SHIFT_CLK_IN) && !SELECT_IN);
    cover property ($rose(f));
endmodule : dssr_top_monitor
bind dssr_top dssr_top_monitor #(.REG_LEN(REG_LEN)) mon (.*);
`default_nettype wire

// File: dssr_ctrl_model.sv
// Purpose: Controller model. Assumes: Bench calls pulse. Notes: Pins move after clock edges.
`timescale 1ns/1ps
`default_nettype none
module dssr_ctrl_model
    import dssr_pkg::*;
(
    input wire logic clk_in,
    output var dssr_pins_type pins_out
);
    initial pins_out = '0;
    task automatic pulse(input logic s, input logic a, input logic b, input int hi);
        @(posedge clk_in);
        pins_out <= '{shift_clk: 1'b1, select: s, data_a: a, data_b: b};
        repeat (hi) @(posedge clk_in);
        pins_out.shift_clk <= 1'b0;
        repeat (5) @(posedge clk_in);
    endtask : pulse
endmodule : dssr_ctrl_model
`default_nettype wire

// File: tb_dssr_top.sv
// Purpose: Bench. Assumes: Length 480. Notes: Function pb gives pattern bit i.
`timescale 1ns/1ps
`default_nettype none
module tb_dssr_top
    import dssr_pkg::*;
;
    localparam int L = SHORT_LEN;
    logic clk = 1'b0;
    logic rst = 1'b1;
    dssr_pins_type p;
    logic [1:0] q;
    logic f;
    int bad_count = 0;
    int tests_run = 0;
    initial forever #12.5 clk = ~clk;
    dssr_ctrl_model ctrl (.clk_in(clk), .pins_out(p));
    dssr_top #(.REG_LEN(L)) uut (.REF_CLK_IN(clk), .RST_IN(rst), .SHIFT_CLK_IN(p.shift_clk),
        .SELECT_IN(p.select), .FIRST_SERIAL_INPUT_IN(p.data_a),
        .SECOND_SERIAL_INPUT_IN(p.data_b), .FIRST_SERIAL_OUTPUT_OUT(q[1]),
        .SECOND_SERIAL_OUTPUT_OUT(q[0]), .HIGH_TOO_LONG_OUT(f));
    function automatic logic [1:0] pb(input int i);
        return {i[0] ^ i[3], i % 5 == 0};
    endfunction : pb
    task automatic chk(input logic [1:0] g, input logic [1:0] e);
        tests_run++;
        if (g !== e)
        begin
            bad_count++;
            $display("unexpected %0t %h %h", $time, g, e);
        end
    endtask : chk
    task automatic stop_test();
        $display("bad_count %0d tests_run %0d", bad_count, tests_run);
        if (bad_count == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : stop_test
    task automatic write_fill();
        logic [1:0] v;
        for (int i = 0; i < L; i++)
        begin
            v = pb(i);
            ctrl.pulse(1'b1, v[1], v[0], 5);
        end
        repeat (3) @(posedge clk);
        chk(q, pb(0));
    endtask : write_fill
    // Serial inputs carry the inverse of the recirculated bit, so they must be ignored.
    task automatic recirc(input int rest);
        logic [1:0] v;
        for (int j = 0; j < L; j++)
        begin
            v = ~pb(j);
            ctrl.pulse(1'b0, v[1], v[0], 5);
            repeat (3) @(posedge clk);
            chk(q, pb((j + 1) % L));
            if (j == 9)
            begin
                repeat (rest) @(posedge clk);
                chk(q, pb(j + 1));
            end
        end
    endtask : recirc
    task automatic long_high();
        fork
            ctrl.pulse(1'b0, 1'b0, 1'b0, 4100);
            begin
                repeat (3985) @(posedge clk);
                chk({1'b0, f}, 2'h0);
                repeat (100) @(posedge clk);
                chk({1'b0, f}, 2'h1);
            end
        join
        repeat (3) @(posedge clk);
        chk({1'b0, f}, 2'h0);
        chk(q, pb(1));
    endtask : long_high
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        write_fill();
        recirc(1000);
        recirc(0);
        long_high();
        stop_test();
    end
    initial
    begin
        repeat (40000) @(posedge clk);
        bad_count++;
        stop_test();
    end
endmodule : tb_dssr_top
`default_nettype wire
